// *** scsa_pkg.sv ***
// Package for the management-interrupt cause status aggregator.
// Assumes a single 40 MHz clock and an I/O port decoded by the caller.
package scsa_pkg;

  // Register offset relative to the power-management I/O base
  localparam logic [7:0]  CAUSE_OFFSET     = 8'h34;
  localparam logic [15:0] CAUSE_RESET      = 16'h0000;

  // Field positions in the cause status register
  localparam int BIT_SERIAL   = 15;
  localparam int BIT_MINUTE   = 14;
  localparam int BIT_HEALTH   = 13;
  localparam int BIT_DEVWATCH = 12;
  localparam int BIT_GRP_B    = 10;
  localparam int BIT_GRP_A    = 9;
  localparam int BIT_POWER    = 8;
  localparam int BIT_TIMER    = 6;
  localparam int BIT_APM      = 5;
  localparam int BIT_SLEEP    = 4;
  localparam int BIT_LEGACY   = 3;
  localparam int BIT_FIRMWARE = 2;

  // Power event register bit that never feeds the aggregate
  localparam int POWER_EXCLUDED_BIT = 5;

  // Clock rate and timing figures
  localparam int CLK_HZ        = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MINUTE_S      = 60;
  localparam int SOFT_TIMER_MS = 64;
  localparam longint MINUTE_CYCLES_L = longint'(MINUTE_S) * longint'(CLK_HZ);
  localparam int MINUTE_CYCLES   = int'(MINUTE_CYCLES_L);
  localparam int SOFT_TIMER_CYCLES = (SOFT_TIMER_MS * (CLK_HZ / 1000));
  localparam int HIGH_HOLD_CLKS  = 4;
  localparam logic [2:0] HIGH_HOLD_INIT = 3'h0;

  // Interrupt line arbitration states
  typedef enum logic [2:0] {
    ARB_IDLE   = 3'b001,
    ARB_HOLD   = 3'b010,
    ARB_ACTIVE = 3'b100
  } scsa_arb_t;

  // Host register access strobes
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  offset;
    logic [15:0] wdata;
  } scsa_io_t;

  // Summary signals from sources kept outside this block
  typedef struct packed {
    logic        serial_irq_cause;
    logic        health_monitor_cause;
    logic [15:0] io_watch_status_enable;
    logic [15:0] device_activity_status;
    logic [15:0] event_group_b_cause;
    logic [15:0] event_group_b_enable;
    logic [15:0] input_event_routing;
    logic [15:0] event_group_a_cause;
    logic [15:0] event_group_a_enable;
    logic [15:0] power_event_cause;
    logic [7:0]  legacy_status;
    logic [7:0]  legacy_enable;
  } scsa_src_t;

  // Latched event pulses and control levels
  typedef struct packed {
    logic apm_write;
    logic sleep_request_one;
    logic global_release_one;
    logic minute_tick_enable;
    logic apm_port_trap_enable;
    logic sleep_trap_enable;
    logic firmware_attention_enable;
    logic soft_timer_start;
    logic global_mgmt_irq_enable;
    logic end_of_handler_set;
  } scsa_ctl_t;

endpackage : scsa_pkg

// *** scsa_soft_timer.sv ***
// Software interrupt timer: one expiry pulse per start.
// Assumes the start level comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module scsa_soft_timer #(
  parameter int TIMER_CYCLES = scsa_pkg::SOFT_TIMER_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic start_in,
  output logic      expire_out
);

  // Whole state of the timer
  typedef struct packed {
    logic [31:0] count;
    logic        done;
    logic        pulse;
  } scsa_tmr_t;

  scsa_tmr_t state_reg;
  scsa_tmr_t state_next;

  // Count while started; clearing start resets and suppresses expiry
  always_comb
  begin
    state_next       = state_reg;
    state_next.pulse = 1'b0;
    if (!start_in)
    begin
      state_next.count = 32'h0;
      state_next.done  = 1'b0;
    end
    else if (!state_reg.done)
    begin
      if (state_reg.count == 32'(TIMER_CYCLES - 1))
      begin
        state_next.done  = 1'b1;
        state_next.pulse = 1'b1;
      end
      else
      begin
        state_next.count = state_reg.count + 32'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign expire_out = state_reg.pulse;

  // Start dropped means no expiry next cycle
  stop_no_pulse_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !start_in |=> !expire_out)
    else $error("soft timer expired after stop");

endmodule : scsa_soft_timer
`default_nettype wire

// *** scsa_cause_status.sv ***
// Management-interrupt cause status register and interrupt arbiter.
// Assumes the I/O strobes are already decoded for the power-management
// range and that the source summaries come from logic on this clock.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Cause status at 34h, resets to zero
// - Enabled latched cause requests management interrupt
// - Bit 15 follows serial decoder request live
// - Bit 14 set each minute, write-one clears
// - Bit 13 shows health monitor cause
// - Bit 12 ORs watch and activity bits 13:12
// - Bit 10 ORs routed, enabled group B
// - Bit 9 ORs enabled group A events
// - Bit 8 ORs power events except 5
// - Bit 6 set on timer expiry
// - Bit 5 set on enabled APM write
// - Bit 4 set on trapped sleep request
// - Bit 3 ORs enabled legacy trap bits
// - Bit 2 set on enabled global release
// - No interrupt while global enable clear
// - End-of-handler gates; four clocks high first
// - Soft timer 64 ms, stop cancels
module scsa_cause_status #(
  parameter int MINUTE_CYCLES = scsa_pkg::MINUTE_CYCLES
) (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire scsa_pkg::scsa_io_t  io_in,
  input  wire scsa_pkg::scsa_src_t src_in,
  input  wire scsa_pkg::scsa_ctl_t ctl_in,
  output logic [15:0]              rdata_out,
  output logic                     mgmt_interrupt_n_out,
  output logic                     end_of_handler_out
);

  // Write-one-to-clear decode of one bit
  function automatic logic w1c(input scsa_pkg::scsa_io_t io, input int pos);
    w1c = io.wr && (io.offset == scsa_pkg::CAUSE_OFFSET) && io.wdata[pos];
  endfunction

  // Whole state of the block
  typedef struct packed {
    logic [31:0]         minute_count;  // Minute divider
    logic                minute_cause;  // Bit 14
    logic                timer_cause;   // Bit 6
    logic                apm_cause;     // Bit 5
    logic                sleep_cause;   // Bit 4
    logic                fw_cause;      // Bit 2
    logic                eoh;           // End-of-handler
    scsa_pkg::scsa_arb_t arb;           // Line arbiter
    logic [2:0]          hold;          // High-hold counter
    logic                irq_n;         // Interrupt line
    logic [15:0]         rdata;         // Read data
  } scsa_state_t;

  scsa_state_t state_reg;
  scsa_state_t state_next;

  logic        timer_expire;   // Soft timer expiry pulse
  logic        minute_tick;    // Minute divider wrap
  logic [15:0] status;         // Assembled status view
  logic        request;        // Any enabled cause
  logic [15:0] power_masked;   // Power events minus excluded bit

  // Soft timer instance
  scsa_soft_timer #(
    .TIMER_CYCLES (scsa_pkg::SOFT_TIMER_CYCLES)
  ) u_timer (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .start_in   (ctl_in.soft_timer_start),
    .expire_out (timer_expire)
  );

  assign minute_tick = (state_reg.minute_count == 32'(MINUTE_CYCLES - 1));

  // Aggregate and latched bits into the status view
  always_comb
  begin
    power_masked = src_in.power_event_cause;
    power_masked[scsa_pkg::POWER_EXCLUDED_BIT] = 1'b0;
    status = scsa_pkg::CAUSE_RESET;  // Reserved bits stay zero
    status[scsa_pkg::BIT_SERIAL]   = src_in.serial_irq_cause;
    status[scsa_pkg::BIT_MINUTE]   = state_reg.minute_cause;
    status[scsa_pkg::BIT_HEALTH]   = src_in.health_monitor_cause;
    status[scsa_pkg::BIT_DEVWATCH] = |src_in.io_watch_status_enable[13:12]
                                   | (|src_in.device_activity_status[13:12]);
    status[scsa_pkg::BIT_GRP_B]    = |(src_in.event_group_b_cause
                                   & src_in.event_group_b_enable
                                   & src_in.input_event_routing);
    status[scsa_pkg::BIT_GRP_A]    = |(src_in.event_group_a_cause
                                   & src_in.event_group_a_enable);
    status[scsa_pkg::BIT_POWER]    = |power_masked;
    status[scsa_pkg::BIT_TIMER]    = state_reg.timer_cause;
    status[scsa_pkg::BIT_APM]      = state_reg.apm_cause;
    status[scsa_pkg::BIT_SLEEP]    = state_reg.sleep_cause;
    status[scsa_pkg::BIT_LEGACY]   = |(src_in.legacy_status & src_in.legacy_enable);
    status[scsa_pkg::BIT_FIRMWARE] = state_reg.fw_cause;
  end

  // Interrupt request: minute bit with its enable, other latched bits and aggregates stand alone
  assign request = (state_reg.minute_cause & ctl_in.minute_tick_enable)
                 | state_reg.timer_cause | state_reg.apm_cause
                 | state_reg.sleep_cause | state_reg.fw_cause
                 | status[scsa_pkg::BIT_SERIAL] | status[scsa_pkg::BIT_HEALTH]
                 | status[scsa_pkg::BIT_DEVWATCH] | status[scsa_pkg::BIT_GRP_B]
                 | status[scsa_pkg::BIT_GRP_A] | status[scsa_pkg::BIT_POWER]
                 | status[scsa_pkg::BIT_LEGACY];

  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    // Minute divider
    state_next.minute_count = minute_tick ? 32'h0 : state_reg.minute_count + 32'h1;
    // Sticky causes: set beats a same-cycle clear
    if (w1c(io_in, scsa_pkg::BIT_MINUTE))
      state_next.minute_cause = 1'b0;
    if (minute_tick)
      state_next.minute_cause = 1'b1;
    if (w1c(io_in, scsa_pkg::BIT_TIMER))
      state_next.timer_cause = 1'b0;
    if (timer_expire)
      state_next.timer_cause = 1'b1;
    if (w1c(io_in, scsa_pkg::BIT_APM))
      state_next.apm_cause = 1'b0;
    if (ctl_in.apm_write && ctl_in.apm_port_trap_enable)
      state_next.apm_cause = 1'b1;
    if (w1c(io_in, scsa_pkg::BIT_SLEEP))
      state_next.sleep_cause = 1'b0;
    if (ctl_in.sleep_request_one && ctl_in.sleep_trap_enable)
      state_next.sleep_cause = 1'b1;
    if (w1c(io_in, scsa_pkg::BIT_FIRMWARE))
      state_next.fw_cause = 1'b0;
    if (ctl_in.global_release_one && ctl_in.firmware_attention_enable)
      state_next.fw_cause = 1'b1;
    // End-of-handler set by the handler
    if (ctl_in.end_of_handler_set)
      state_next.eoh = 1'b1;
    // Read data registered
    state_next.rdata = (io_in.rd && io_in.offset == scsa_pkg::CAUSE_OFFSET)
                     ? status : 16'h0;
    // Line arbiter
    case (state_reg.arb)
      scsa_pkg::ARB_IDLE:
      begin
        state_next.irq_n = 1'b1;
        state_next.hold  = scsa_pkg::HIGH_HOLD_INIT;
        if (state_reg.eoh && request && ctl_in.global_mgmt_irq_enable)
          state_next.arb = scsa_pkg::ARB_HOLD;
      end
      scsa_pkg::ARB_HOLD:
      begin
        // Enable dropped during hold: give up, line never goes low
        if (!ctl_in.global_mgmt_irq_enable)
        begin
          state_next.arb = scsa_pkg::ARB_IDLE;
        end
        // Keep line high four clocks before asserting
        else if (state_reg.hold == 3'(scsa_pkg::HIGH_HOLD_CLKS - 1))
        begin
          state_next.irq_n = 1'b0;
          state_next.eoh   = 1'b0;
          state_next.arb   = scsa_pkg::ARB_ACTIVE;
        end
        else
        begin
          state_next.hold = state_reg.hold + 3'h1;
        end
      end
      scsa_pkg::ARB_ACTIVE:
      begin
        // Release once handler sets end-of-handler again
        if (ctl_in.end_of_handler_set || !ctl_in.global_mgmt_irq_enable)
        begin
          state_next.irq_n = 1'b1;
          state_next.arb   = scsa_pkg::ARB_IDLE;
        end
      end
      default:
      begin
        state_next.arb   = scsa_pkg::ARB_IDLE;
        state_next.irq_n = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg       <= '0;
      state_reg.arb   <= scsa_pkg::ARB_IDLE;
      state_reg.irq_n <= 1'b1;
      state_reg.eoh   <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rdata_out            = state_reg.rdata;
  assign mgmt_interrupt_n_out = state_reg.irq_n;
  assign end_of_handler_out   = state_reg.eoh;

  // Reserved bits always read zero
  reserved_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    rdata_out[11] == 1'b0 && rdata_out[7] == 1'b0 && rdata_out[1:0] == 2'h0)
    else $error("reserved bit read nonzero");

  // Line goes low only after four high clocks in hold
  low_after_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(mgmt_interrupt_n_out) |-> $past(mgmt_interrupt_n_out, 4))
    else $error("interrupt asserted without high hold");

  // Line only falls while the global enable was set
  gate_on_fall_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(mgmt_interrupt_n_out) |-> $past(ctl_in.global_mgmt_irq_enable))
    else $error("interrupt asserted while disabled");

  // Assertion clears end-of-handler
  eoh_cleared_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(mgmt_interrupt_n_out) |-> !end_of_handler_out)
    else $error("end of handler not cleared");

  // No assertion with global enable off
  global_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg.arb == scsa_pkg::ARB_IDLE && !ctl_in.global_mgmt_irq_enable)
      |=> state_reg.arb == scsa_pkg::ARB_IDLE)
    else $error("arbiter left idle while disabled");

  // Timer expiry latches bit 6
  timer_latch_a: assert property (@(posedge clk_in) disable iff (rst_in)
    timer_expire |=> state_reg.timer_cause)
    else $error("timer cause not latched");

  // APM trap latches bit 5
  apm_latch_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ctl_in.apm_write && ctl_in.apm_port_trap_enable |=> state_reg.apm_cause)
    else $error("apm cause not latched");

  // Sleep trap latches bit 4
  sleep_latch_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ctl_in.sleep_request_one && ctl_in.sleep_trap_enable |=> state_reg.sleep_cause)
    else $error("sleep cause not latched");

  // Release latches bit 2
  fw_latch_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ctl_in.global_release_one && ctl_in.firmware_attention_enable |=> state_reg.fw_cause)
    else $error("firmware cause not latched");

  // Minute tick latches bit 14
  minute_latch_a: assert property (@(posedge clk_in) disable iff (rst_in)
    minute_tick |=> state_reg.minute_cause)
    else $error("minute cause not latched");

  // Zero write leaves the APM sticky bit alone
  zero_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
    io_in.wr && io_in.offset == scsa_pkg::CAUSE_OFFSET && !io_in.wdata[scsa_pkg::BIT_APM]
      && state_reg.apm_cause |=> state_reg.apm_cause)
    else $error("zero write cleared a bit");

  // Live bit 15 readback
  serial_live_a: assert property (@(posedge clk_in) disable iff (rst_in)
    io_in.rd && io_in.offset == scsa_pkg::CAUSE_OFFSET
      |=> rdata_out[15] == $past(src_in.serial_irq_cause))
    else $error("serial cause readback wrong");

endmodule : scsa_cause_status
`default_nettype wire

// *** scsa_host_model.sv ***
// Host handler model facing the interrupt line of the cause aggregator.
// Assumes the bench clears pending causes before the handler delay ends.
`timescale 1ns/1ps
`default_nettype none
module scsa_host_model (
  input  wire logic       clk_in,              // Bench clock
  input  wire logic       rst_in,              // Active-high reset
  input  wire logic       mgmt_interrupt_n_in, // Line from the device
  input  wire logic [7:0] delay_in,            // Handler length in cycles
  output logic            eoh_set_out          // One-cycle end-of-handler pulse
);
  // Handler: on entry wait, then set end-of-handler exactly once
  initial
  begin
    eoh_set_out = 1'b0;
    forever
    begin
      @(negedge clk_in);
      eoh_set_out = 1'b0;
      // Entry only while the line is low and out of reset
      if (!rst_in && mgmt_interrupt_n_in === 1'b0)
      begin
        repeat (delay_in) @(negedge clk_in);
        eoh_set_out = 1'b1;
      end
    end
  end
endmodule // scsa_host_model
`default_nettype wire

// *** tb_smi_cause_status_aggregator.sv ***
// Self-checking bench for the cause status register and interrupt line.
// Assumes the design package is compiled first and a short minute count.
`timescale 1ns/1ps
`default_nettype none
module tb_smi_cause_status_aggregator;
  localparam int MIN_CYC = 50;  // Shortened minute for simulation
  logic                clk_in;  // 40 MHz clock
  logic                rst_in;  // Active-high reset
  scsa_pkg::scsa_io_t  io;      // Register strobes
  scsa_pkg::scsa_src_t src;     // Source summaries
  scsa_pkg::scsa_ctl_t ctl;     // Event pulses and enables
  scsa_pkg::scsa_ctl_t ctl_w;   // Controls with the host pulse merged
  logic [15:0]         rdata;   // Read data
  logic                irq_n;   // Interrupt line
  logic                eoh;     // End-of-handler flag
  logic                eoh_set; // Host end-of-handler pulse
  logic [7:0]          hdelay;  // Host handler length
  logic [15:0]         got;     // Last read value
  int                  n_mismatch;
  int                  num_checks;
  int                  cnt;
  int                  ks[2] = '{0, 2};
  logic [7:0]          dl[2] = '{8'h06, 8'h28};

  assign ctl_w = {ctl[$bits(ctl)-1:1], eoh_set};

  scsa_cause_status #(.MINUTE_CYCLES(MIN_CYC)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .io_in(io), .src_in(src), .ctl_in(ctl_w),
    .rdata_out(rdata), .mgmt_interrupt_n_out(irq_n), .end_of_handler_out(eoh));

  scsa_host_model host (
    .clk_in(clk_in), .rst_in(rst_in), .mgmt_interrupt_n_in(irq_n),
    .delay_in(hdelay), .eoh_set_out(eoh_set));

  // Clock generator
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // Compare and report
  task automatic check(input logic [15:0] exp, input logic [15:0] act);
    num_checks++;
    if (act !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Register read: data stands the cycle after the taking edge
  task automatic rd(input logic [7:0] off, output logic [15:0] d);
    @(negedge clk_in);
    io.rd = 1'b1;
    io.offset = off;
    @(negedge clk_in);
    io.rd = 1'b0;
    d = rdata;
  endtask

  // Register write at the cause status offset
  task automatic wr(input logic [15:0] v);
    @(negedge clk_in);
    io.wr = 1'b1;
    io.offset = scsa_pkg::CAUSE_OFFSET;
    io.wdata = v;
    @(negedge clk_in);
    io.wr = 1'b0;
  endtask

  // One-cycle event pulse: 0 APM, 1 sleep, 2 global release
  task automatic pulse(input int k);
    @(negedge clk_in);
    case (k)
      0: ctl.apm_write = 1'b1;
      1: ctl.sleep_request_one = 1'b1;
      default: ctl.global_release_one = 1'b1;
    endcase
    @(negedge clk_in);
    ctl.apm_write = 1'b0;
    ctl.sleep_request_one = 1'b0;
    ctl.global_release_one = 1'b0;
  endtask

  // Enable level of event k
  task automatic en(input int k, input logic v);
    case (k)
      0: ctl.apm_port_trap_enable = v;
      1: ctl.sleep_trap_enable = v;
      default: ctl.firmware_attention_enable = v;
    endcase
  endtask

  // Wait for the handler pulse, then the line must be high again
  task automatic wait_release();
    cnt = 0;
    while (eoh_set !== 1'b1 && cnt < 60)
    begin
      @(posedge clk_in);
      cnt++;
    end
    check(16'h0001, {15'h0, cnt < 60});
    @(negedge clk_in);
    check(16'h0003, {14'h0, irq_n, eoh});
    repeat (10) @(negedge clk_in);
    check(16'h0001, {15'h0, irq_n});
  endtask

  // Sticky status bit of event k
  function automatic logic [15:0] stbit(input int k);
    return (k == 0) ? 16'h0020 : (k == 1) ? 16'h0010 : 16'h0004;
  endfunction

  // Expected live aggregate bits
  function automatic logic [15:0] agg(input scsa_pkg::scsa_src_t s);
    logic [15:0] e;
    e = 16'h0000;
    e[15] = s.serial_irq_cause;
    e[13] = s.health_monitor_cause;
    e[12] = |{s.io_watch_status_enable[13:12], s.device_activity_status[13:12]};
    e[10] = |(s.event_group_b_cause & s.event_group_b_enable & s.input_event_routing);
    e[9] = |(s.event_group_a_cause & s.event_group_a_enable);
    e[8] = |(s.power_event_cause & 16'hffdf);
    e[3] = |(s.legacy_status & s.legacy_enable);
    return e;
  endfunction

  // Watchdog against a hang
  initial
  begin
    #(25 * 20000);
    n_mismatch++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    rst_in = 1'b1;
    io = '0;
    src = '0;
    ctl = '0;
    hdelay = 8'h06;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(32'h6672));
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    check(16'h0003, {14'h0, irq_n, eoh});
    rd(8'h34, got);
    check(scsa_pkg::CAUSE_RESET, got);
    rd(8'h36, got);
    check(16'h0000, got);
    // Live aggregates: sparse random sources, excluded power bit first
    for (int i = 0; i < 60; i++)
    begin
      @(negedge clk_in);
      for (int j = 0; j < $bits(src); j++)
        src[j] = ($urandom_range(0, 7) == 0);
      if (i == 0)
        src = '0;
      if (i == 0)
        src.power_event_cause = 16'h0020;
      ctl.soft_timer_start = $urandom_range(0, 1);
      rd(8'h34, got);
      check(agg(src), got & 16'hbfff);
      check(16'h0001, {15'h0, irq_n});
    end
    ctl.soft_timer_start = 1'b0;
    src = '0;
    // Minute tick sets bit 14, write of one clears it
    cnt = 0;
    got = 16'h0000;
    while (got[14] !== 1'b1 && cnt < 60)
    begin
      rd(8'h34, got);
      cnt++;
    end
    check(16'h4000, got);
    wr(16'h4000);
    rd(8'h34, got);
    check(16'h0000, got);
    // Sticky events: enable gating, zero writes ignored, one clears
    for (int k = 0; k < 3; k++)
    begin
      en(k, 1'b0);
      pulse(k);
      rd(8'h34, got);
      check(16'h0000, got & 16'hbfff);
      en(k, 1'b1);
      pulse(k);
      wr(~stbit(k) & 16'hbfff);
      rd(8'h34, got);
      check(stbit(k), got & 16'hbfff);
      check(16'h0001, {15'h0, irq_n});
      wr(stbit(k));
      rd(8'h34, got);
      check(16'h0000, got & 16'hbfff);
      en(k, 1'b0);
    end
    // Interrupt line: prompt and slow handlers
    ctl.global_mgmt_irq_enable = 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      hdelay = dl[m];
      en(ks[m], 1'b1);
      pulse(ks[m]);
      cnt = 0;
      while (irq_n !== 1'b0 && cnt < 20)
      begin
        @(negedge clk_in);
        cnt++;
      end
      check(16'h0001, {15'h0, cnt >= 5 && cnt <= 7});
      check(16'h0000, {15'h0, eoh});
      wr(stbit(ks[m]));
      wait_release();
      en(ks[m], 1'b0);
    end
    // Minute tick with its enable drives the line low
    hdelay = 8'h06;
    wr(16'h4000);
    ctl.minute_tick_enable = 1'b1;
    cnt = 0;
    while (irq_n !== 1'b0 && cnt < 80)
    begin
      @(negedge clk_in);
      cnt++;
    end
    check(16'h0001, {15'h0, cnt < 80});
    rd(8'h34, got);
    check(16'h4000, got);
    wr(16'h4000);
    wait_release();
    ctl.minute_tick_enable = 1'b0;
    // Global enable clear blocks the line
    ctl.global_mgmt_irq_enable = 1'b0;
    en(0, 1'b1);
    pulse(0);
    repeat (10) @(negedge clk_in);
    check(16'h0001, {15'h0, irq_n});
    // Mid-run reset drops the pending APM cause
    @(negedge clk_in);
    rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    check(16'h0003, {14'h0, irq_n, eoh});
    rd(8'h34, got);
    check(scsa_pkg::CAUSE_RESET, got);
    end_sim();
  end
endmodule // tb_smi_cause_status_aggregator
`default_nettype wire
